// file: bench/acpcr_host.sv
`timescale 1ns/1ps
`default_nettype none
module acpcr_host (
  // clock
  input wire logic clock,
  // control port pins
  input wire logic ctrl_data_out,
  input wire logic ctrl_data_oe,
  output logic ctrl_clk,
  output logic ctrl_latch_n,
  output logic ctrl_data_in
);
  // ----------------------------------------------------------------
  // idle pins
  // ----------------------------------------------------------------
  // clock idles low, latch idles high
  initial begin
    ctrl_clk = 1'b0;
    ctrl_latch_n = 1'b1;
    ctrl_data_in = 1'b0;
  end

  // ----------------------------------------------------------------
  // one control frame
  // ----------------------------------------------------------------
  // msb first, data set while the clock is low; ph sets prompt or slow
  // phases; a read bit seen without drive becomes x so it never matches
  task automatic frame(input logic [23:0] word, input int nbits,
                       input int ph, output logic [7:0] rd);
    rd = 8'h00;
    @(negedge clock);
    ctrl_latch_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      ctrl_data_in = word[23 - i];
      repeat (ph) @(negedge clock);
      if (i >= 16) begin
        rd = {rd[6:0], ctrl_data_oe ? ctrl_data_out : 1'bx};
      end
      ctrl_clk = 1'b1;
      repeat (ph) @(negedge clock);
      ctrl_clk = 1'b0;
    end
    repeat (ph) @(negedge clock);
    ctrl_latch_n = 1'b1;
    // the data line keeps no stale value between frames
    ctrl_data_in = ~ctrl_data_in;
    repeat (6) @(negedge clock);
  endtask : frame
endmodule : acpcr_host
`default_nettype wire

// file: bench/tb_adc_clock_port_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adc_clock_port_config_regs;
  import acpcr_pkg::*;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic mult_locked = 1'b0;
  logic master_power_up = 1'b1;
  wire logic ctrl_clk, ctrl_latch_n, ctrl_data_in;
  wire logic ctrl_data_out, ctrl_data_oe;
  logic converter_mute;
  acpcr_mult_t mult_cfg;
  acpcr_power_t power;
  acpcr_port_t port_cfg;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 50489;
  logic [31:0] rnd;
  logic [7:0] rd_val, r01, r04, r05;

  // 40 MHz clock
  always #12.5 clock = ~clock;

  acpcr_top u_acpcr_top (.clock(clock), .reset_n(reset_n),
    .ctrl_clk(ctrl_clk), .ctrl_latch_n(ctrl_latch_n),
    .ctrl_data_in(ctrl_data_in), .ctrl_data_out(ctrl_data_out),
    .ctrl_data_oe(ctrl_data_oe), .mult_locked(mult_locked),
    .mult_cfg(mult_cfg), .converter_mute(converter_mute),
    .master_power_up(master_power_up), .power(power),
    .port_cfg(port_cfg));

  acpcr_host u_acpcr_host (.clock(clock), .ctrl_data_out(ctrl_data_out),
    .ctrl_data_oe(ctrl_data_oe), .ctrl_clk(ctrl_clk),
    .ctrl_latch_n(ctrl_latch_n), .ctrl_data_in(ctrl_data_in));

  // ----------------------------------------------------------------
  // expectations and helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] exp_ratio(input logic [2:0] c);
    case (c)
      3'h0: return 10'h080;
      3'h1: return 10'h100;
      3'h2: return 10'h180;
      3'h3: return 10'h200;
      3'h4: return 10'h300;
      default: return 10'h000;
    endcase
  endfunction : exp_ratio

  function automatic logic [4:0] exp_slots(input logic [2:0] c);
    return (c == 3'h0 || c > 3'h4) ? 5'h00 : 5'h01 << c;
  endfunction : exp_slots

  task automatic chk(input logic [23:0] got, input logic [23:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got,
               exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_acpcr_host.frame({CHIP_ID, 1'b0, a, d}, 24, 5 + {$random(seed)} % 3,
                       rd_val);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string what);
    u_acpcr_host.frame({CHIP_ID, 1'b1, a, 8'h00}, 24, 5, rd_val);
    chk(rd_val, exp, what);
  endtask : rd

  // decoded outputs against the shadow register copies
  task automatic chk_cfg();
    logic [15:0] e_mult;
    logic [5:0] e_pow;
    logic [21:0] e_port;
    logic unsup;
    unsup = r01[4] & (r05[2:0] < 3'h2 || r05[2:0] > 3'h4);
    e_mult = {r01[4], r01[2:0], exp_ratio(r01[2:0]), r01[2:0] > 3'h4, unsup};
    e_pow = r04[5:0] & {6{master_power_up}};
    e_port = {r04[7:6], r05, r05[7:6] == 2'h0, r05[7],
              r05[7:6] == 2'h3 ? 5'h10 : 5'h18, exp_slots(r05[5:3])};
    chk(mult_cfg, e_mult, "mult");
    chk(power, e_pow, "power");
    chk(port_cfg[21:12], e_port[21:12], "fields");
    chk(port_cfg[11:0], e_port[11:0], "decode");
    chk(converter_mute, r01[6] & ~mult_locked, "mute");
  endtask : chk_cfg

  task automatic finish_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  // hang guard, well above the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      $display("Error at %0t: timeout", $time);
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    for (int pass = 0; pass < 2; pass++) begin
      repeat (4) @(negedge clock);
      r01 = 8'h41;
      r04 = 8'h3f;
      r05 = 8'h02;
      chk_cfg();
      rd(OFF_CLK_CTRL, 8'h41, "clk reset");
      rd(OFF_PWR_PORT, 8'h3f, "pwr reset");
      rd(OFF_FMT_RATE, 8'h02, "fmt reset");
      // lock gained then lost with automute on
      mult_locked = 1'b1;
      repeat (6) @(negedge clock);
      chk_cfg();
      rd(OFF_CLK_CTRL, 8'hc1, "lock bit");
      mult_locked = 1'b0;
      repeat (6) @(negedge clock);
      chk_cfg();
      // second pass starts from a reset in mid-run
      @(negedge clock) reset_n = 1'b0;
      repeat (3) @(negedge clock);
      reset_n = 1'b1;
    end
    // lock bit cannot be written; automute off keeps output live
    wr(OFF_CLK_CTRL, 8'h80);
    r01 = 8'h00;
    rd(OFF_CLK_CTRL, 8'h00, "lock ro");
    mult_locked = 1'b1;
    repeat (6) @(negedge clock);
    mult_locked = 1'b0;
    repeat (6) @(negedge clock);
    chk_cfg();
    // every ratio, format and slot code, with random neighbours
    for (int i = 0; i < 16; i++) begin
      rnd = $random(seed);
      r01 = {1'b0, rnd[6:3], i[2:0]};
      r04 = rnd[15:8];
      r05 = {i[1:0], i[3:1], rnd[2:0]};
      wr(OFF_CLK_CTRL, r01);
      wr(OFF_PWR_PORT, r04);
      wr(OFF_FMT_RATE, r05);
      master_power_up = rnd[16] | rnd[17];
      repeat (3) @(negedge clock);
      chk_cfg();
      rd(OFF_CLK_CTRL, r01, "clk rb");
      rd(OFF_PWR_PORT, r04, "pwr rb");
      rd(OFF_FMT_RATE, r05, "fmt rb");
    end
    // refused frames: wrong device code, cut short, unmapped places
    u_acpcr_host.frame({7'h12, 1'b0, OFF_PWR_PORT, 8'h00}, 24, 6, rd_val);
    u_acpcr_host.frame({CHIP_ID, 1'b0, OFF_PWR_PORT, 8'h00}, 20, 6, rd_val);
    wr(8'h03, 8'h5a);
    rd(8'h03, 8'h00, "unmapped");
    chk_cfg();
    finish_test();
  end
endmodule : tb_adc_clock_port_config_regs
`default_nettype wire

// file: logic/acpcr_pkg.sv
`default_nettype none
package acpcr_pkg;

  // ----------------------------------------------------------------
  // register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CLK_CTRL = 8'h01;
  localparam logic [7:0] OFF_PWR_PORT = 8'h04;
  localparam logic [7:0] OFF_FMT_RATE = 8'h05;
  localparam logic [6:0] RST_CLK_CTRL = 7'h41; // bit 7 is live lock state
  localparam logic [7:0] RST_PWR_PORT = 8'h3f;
  localparam logic [7:0] RST_FMT_RATE = 8'h02;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_LOCK = 7;
  localparam int BIT_AUTOMUTE = 6;
  localparam int BIT_SRC = 4;
  localparam int RATIO_LSB = 0;
  localparam int BIT_POLARITY = 7;
  localparam int BIT_LAUNCH = 6;
  localparam int BIT_REGULATOR = 5;
  localparam int BIT_REFERENCE = 4;
  localparam int CHAN_LSB = 0;
  localparam int FMT_LSB = 6;
  localparam int SLOT_LSB = 3;
  localparam int RATE_LSB = 0;

  // ----------------------------------------------------------------
  // field codes
  // ----------------------------------------------------------------
  localparam logic [2:0] RATIO_128 = 3'h0;
  localparam logic [2:0] RATIO_256 = 3'h1;
  localparam logic [2:0] RATIO_384 = 3'h2;
  localparam logic [2:0] RATIO_512 = 3'h3;
  localparam logic [2:0] RATIO_768 = 3'h4;
  localparam logic [1:0] FMT_I2S = 2'h0;
  localparam logic [1:0] FMT_LJ = 2'h1;
  localparam logic [1:0] FMT_RJ24 = 2'h2;
  localparam logic [1:0] FMT_RJ16 = 2'h3;
  localparam logic [2:0] SLOT_STEREO = 3'h0;
  localparam logic [2:0] SLOT_TDM16 = 3'h4;
  localparam logic [2:0] RATE_8_12 = 3'h0;
  localparam logic [2:0] RATE_32_48 = 3'h2;
  localparam logic [2:0] RATE_128_192 = 3'h4;
  // control port device address; value is arbitrary
  localparam logic [6:0] CHIP_ID = 7'h11;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SP_CHIP, SP_REG, SP_DATA, SP_SKIP} acpcr_spi_st_t;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } acpcr_wr_t;

  typedef struct packed {
    logic src_frame;
    logic [2:0] clock_ratio_select;
    logic [9:0] ratio_mult;
    logic ratio_reserved;
    logic src_unsupported;
  } acpcr_mult_t;

  typedef struct packed {
    logic regulator_enable;
    logic reference_enable;
    logic [3:0] channel_enable;
  } acpcr_power_t;

  typedef struct packed {
    logic frame_clock_polarity;
    logic bit_clock_launch_edge;
    logic [1:0] serial_format;
    logic [2:0] port_slot_mode;
    logic [2:0] sample_rate_range;
    logic first_bit_delay;
    logic right_justified;
    logic [4:0] data_bits;
    logic [4:0] slot_count;
  } acpcr_port_t;

endpackage : acpcr_pkg
`default_nettype wire

// file: logic/acpcr_spi.sv
`timescale 1ns/1ps
`default_nettype none
module acpcr_spi (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // synchronised control pins
  input wire logic sclk_s,
  input wire logic latch_n_s,
  input wire logic mosi_s,
  output logic miso,
  output logic miso_oe,
  // register side
  output acpcr_pkg::acpcr_wr_t wr,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);
  import acpcr_pkg::*;

  acpcr_spi_st_t st_r, st_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt, out_r, out_nxt, addr_r, addr_nxt, byte_in;
  logic rw_r, rw_nxt, oe_r, oe_nxt, sclk_q_r, rise, fall;
  acpcr_wr_t wr_r, wr_nxt;

  assign rise = sclk_s & ~sclk_q_r;
  assign fall = ~sclk_s & sclk_q_r;
  assign byte_in = {sh_r[6:0], mosi_s};
  assign miso = out_r[7];
  assign miso_oe = oe_r;
  assign wr = wr_r;
  assign rd_addr = addr_r;

  // frame: device byte, register byte, data byte; sample on rise
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    out_nxt = out_r;
    addr_nxt = addr_r;
    rw_nxt = rw_r;
    oe_nxt = oe_r;
    wr_nxt = wr_r;
    wr_nxt.valid = 1'b0;
    if (latch_n_s) begin
      st_nxt = SP_CHIP;
      cnt_nxt = 3'h0;
      oe_nxt = 1'b0;
    end else begin
      if (rise) begin
        sh_nxt = byte_in;
        cnt_nxt = cnt_r + 3'h1;
        if (cnt_r == 3'h7) begin
          unique case (st_r)
            SP_CHIP: begin
              if (byte_in[7:1] == CHIP_ID) begin
                rw_nxt = byte_in[0];
                st_nxt = SP_REG;
              end else begin
                st_nxt = SP_SKIP;
              end
            end
            SP_REG: begin
              addr_nxt = byte_in;
              st_nxt = SP_DATA;
            end
            SP_DATA: begin
              wr_nxt.valid = ~rw_r;
              wr_nxt.addr = addr_r;
              wr_nxt.data = byte_in;
              st_nxt = SP_SKIP;
            end
            SP_SKIP: st_nxt = SP_SKIP;
          endcase
        end
      end
      // read data launches on falling edges, msb first
      if (fall && st_r == SP_DATA && rw_r) begin
        oe_nxt = 1'b1;
        out_nxt = (cnt_r == 3'h0) ? rd_data : {out_r[6:0], 1'b0};
      end
      if (fall && st_r == SP_SKIP) begin
        oe_nxt = 1'b0;
      end
    end
  end

  // state registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= SP_CHIP;
      cnt_r <= 3'h0;
      sh_r <= 8'h00;
      out_r <= 8'h00;
      addr_r <= 8'h00;
      rw_r <= 1'b0;
      oe_r <= 1'b0;
      wr_r <= '0;
      sclk_q_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      out_r <= out_nxt;
      addr_r <= addr_nxt;
      rw_r <= rw_nxt;
      oe_r <= oe_nxt;
      wr_r <= wr_nxt;
      sclk_q_r <= sclk_s;
    end
  end
endmodule : acpcr_spi
`default_nettype wire

// file: logic/acpcr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module acpcr_sync (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // crossing
  input wire logic async_in,
  output logic sync_out
);
  logic meta_r;

  // two stages; only the second stage is read outside
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : acpcr_sync
`default_nettype wire

// file: logic/acpcr_top.sv
`timescale 1ns/1ps
`default_nettype none
module acpcr_top (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // control port pins
  input wire logic ctrl_clk,
  input wire logic ctrl_latch_n,
  input wire logic ctrl_data_in,
  output logic ctrl_data_out,
  output logic ctrl_data_oe,
  // clock multiplier
  input wire logic mult_locked,
  output acpcr_pkg::acpcr_mult_t mult_cfg,
  output logic converter_mute,
  // power
  input wire logic master_power_up,
  output acpcr_pkg::acpcr_power_t power,
  // serial port setup
  output acpcr_pkg::acpcr_port_t port_cfg
);
  import acpcr_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_raw, pin_s;
  logic sclk_s, latch_n_s, mosi_s, lock_s;

  assign pin_raw = {mult_locked, ctrl_data_in, ctrl_latch_n, ctrl_clk};
  assign sclk_s = pin_s[0];
  assign latch_n_s = pin_s[1];
  assign mosi_s = pin_s[2];
  assign lock_s = pin_s[3];

  // the three control input pins and the lock pin are asynchronous to clock
  generate
    for (genvar i = 0; i < 4; i++) begin : g_sync
      acpcr_sync u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .async_in(pin_raw[i]),
        .sync_out(pin_s[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // control port
  // ----------------------------------------------------------------
  acpcr_wr_t wr;
  logic [7:0] rd_addr, rd_data;

  acpcr_spi u_spi (
    .clock(clock),
    .reset_n(reset_n),
    .sclk_s(sclk_s),
    .latch_n_s(latch_n_s),
    .mosi_s(mosi_s),
    .miso(ctrl_data_out),
    .miso_oe(ctrl_data_oe),
    .wr(wr),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // 0 unmapped, 1 clock control, 2 power/edges, 3 format/rate
  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    logic [1:0] s;
    s = 2'h0;
    if (a == OFF_CLK_CTRL) s = 2'h1;
    if (a == OFF_PWR_PORT) s = 2'h2;
    if (a == OFF_FMT_RATE) s = 2'h3;
    return s;
  endfunction : reg_sel

  // reserved codes give zero so downstream can refuse them
  function automatic logic [9:0] ratio_mult(input logic [2:0] c);
    logic [9:0] m;
    m = 10'h000;
    unique case (c)
      RATIO_128: m = 10'h080;
      RATIO_256: m = 10'h100;
      RATIO_384: m = 10'h180;
      RATIO_512: m = 10'h200;
      RATIO_768: m = 10'h300;
      default: m = 10'h000;
    endcase
    return m;
  endfunction : ratio_mult

  // ----------------------------------------------------------------
  // register bank
  // ----------------------------------------------------------------
  logic [6:0] clk_r, clk_nxt;
  logic [7:0] pwr_r, pwr_nxt, fmt_r, fmt_nxt;

  // lock bit is not stored, so writes to it fall away
  always_comb begin
    clk_nxt = clk_r;
    pwr_nxt = pwr_r;
    fmt_nxt = fmt_r;
    if (wr.valid) begin
      unique case (reg_sel(wr.addr))
        2'h1: clk_nxt = wr.data[6:0];
        2'h2: pwr_nxt = wr.data;
        2'h3: fmt_nxt = wr.data;
        default: clk_nxt = clk_r;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clk_r <= RST_CLK_CTRL;
      pwr_r <= RST_PWR_PORT;
      fmt_r <= RST_FMT_RATE;
    end else begin
      clk_r <= clk_nxt;
      pwr_r <= pwr_nxt;
      fmt_r <= fmt_nxt;
    end
  end

  // readback is combinational; the port samples it on a falling edge
  always_comb begin
    unique case (reg_sel(rd_addr))
      2'h1: rd_data = {lock_s, clk_r};
      2'h2: rd_data = pwr_r;
      2'h3: rd_data = fmt_r;
      default: rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // decoded outputs
  // ----------------------------------------------------------------
  acpcr_mult_t mult_r, mult_nxt;
  acpcr_power_t pow_r, pow_nxt;
  acpcr_port_t port_r, port_nxt;
  logic mute_r, mute_nxt;
  logic [1:0] fmt_f;
  logic [2:0] slot_f, rate_f;

  assign fmt_f = fmt_nxt[FMT_LSB +: 2];
  assign slot_f = fmt_nxt[SLOT_LSB +: 3];
  assign rate_f = fmt_nxt[RATE_LSB +: 3];

  // computed from next values so outputs change on the same edge as the registers
  always_comb begin
    mult_nxt.src_frame = clk_nxt[BIT_SRC];
    mult_nxt.clock_ratio_select = clk_nxt[RATIO_LSB +: 3];
    mult_nxt.ratio_mult = ratio_mult(clk_nxt[RATIO_LSB +: 3]);
    mult_nxt.ratio_reserved = clk_nxt[RATIO_LSB +: 3] > RATIO_768;
    // frame clock is not a usable reference below 32 kHz
    mult_nxt.src_unsupported = clk_nxt[BIT_SRC] &
      ((rate_f < RATE_32_48) | (rate_f > RATE_128_192));
    // master power-up low overrides every block enable
    pow_nxt.regulator_enable =
      pwr_nxt[BIT_REGULATOR] & master_power_up;
    pow_nxt.reference_enable =
      pwr_nxt[BIT_REFERENCE] & master_power_up;
    pow_nxt.channel_enable =
      pwr_nxt[CHAN_LSB +: 4] & {4{master_power_up}};
    port_nxt.frame_clock_polarity = pwr_nxt[BIT_POLARITY];
    port_nxt.bit_clock_launch_edge = pwr_nxt[BIT_LAUNCH];
    port_nxt.serial_format = fmt_f;
    port_nxt.port_slot_mode = slot_f;
    port_nxt.sample_rate_range = rate_f;
    port_nxt.first_bit_delay = (fmt_f == FMT_I2S);
    port_nxt.right_justified =
      (fmt_f == FMT_RJ24) | (fmt_f == FMT_RJ16);
    port_nxt.data_bits = (fmt_f == FMT_RJ16) ? 5'h10 : 5'h18;
    // slot count 0 means stereo; reserved codes also read as stereo
    port_nxt.slot_count = 5'h00;
    if (slot_f != SLOT_STEREO && slot_f <= SLOT_TDM16) begin
      port_nxt.slot_count = 5'h01 << slot_f;
    end
    mute_nxt = clk_nxt[BIT_AUTOMUTE] & ~lock_s;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mult_r <= '0;
      pow_r <= '0;
      port_r <= '0;
      mute_r <= 1'b1;
    end else begin
      mult_r <= mult_nxt;
      pow_r <= pow_nxt;
      port_r <= port_nxt;
      mute_r <= mute_nxt;
    end
  end

  assign mult_cfg = mult_r;
  assign power = pow_r;
  assign port_cfg = port_r;
  assign converter_mute = mute_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // lock readback follows the pin two flops later; the first two edges
  // after reset still show the flushed synchroniser, so they are skipped
  a_lock_readback: assert property (
    @(posedge clock) disable iff (!reset_n)
    $past(reset_n, 2) && reg_sel(rd_addr) == 2'h1 |->
    rd_data[BIT_LOCK] == $past(mult_locked, 2))
    else $error("lock readback differs from lock pin");

  // mute is registered, so it shows one edge after the lock loss
  a_mute_on_unlock: assert property (
    @(posedge clock) disable iff (!reset_n)
    $fell(lock_s) && clk_r[BIT_AUTOMUTE] && !wr.valid |=> converter_mute)
    else $error("no mute after lock loss");

  a_no_automute: assert property (
    @(posedge clock) disable iff (!reset_n)
    !clk_r[BIT_AUTOMUTE] |-> !converter_mute)
    else $error("mute asserted with automute off");

  a_frame_src_range: assert property (
    @(posedge clock) disable iff (!reset_n)
    mult_cfg.src_unsupported |-> mult_cfg.src_frame &&
    (port_cfg.sample_rate_range < RATE_32_48 ||
    port_cfg.sample_rate_range > RATE_128_192))
    else $error("source range flag wrong");

  a_src_select: assert property (
    @(posedge clock) disable iff (!reset_n)
    wr.valid && reg_sel(wr.addr) == 2'h1 |=>
    mult_cfg.src_frame == $past(wr.data[BIT_SRC]))
    else $error("source select not applied");

  a_ratio_write: assert property (
    @(posedge clock) disable iff (!reset_n)
    wr.valid && reg_sel(wr.addr) == 2'h1 && wr.data[2:0] == RATIO_512
    |=> mult_cfg.ratio_mult == 10'h200 && !mult_cfg.ratio_reserved)
    else $error("ratio 512 not applied");

  a_ratio_reserved: assert property (
    @(posedge clock) disable iff (!reset_n)
    mult_cfg.ratio_reserved |-> mult_cfg.ratio_mult == 10'h000 &&
    mult_cfg.clock_ratio_select > RATIO_768)
    else $error("reserved ratio decode wrong");

  a_launch_edge: assert property (
    @(posedge clock) disable iff (!reset_n)
    wr.valid && reg_sel(wr.addr) == 2'h2 |=> port_cfg.bit_clock_launch_edge
    == $past(wr.data[BIT_LAUNCH]) && port_cfg.frame_clock_polarity
    == $past(wr.data[BIT_POLARITY]))
    else $error("edge or polarity not applied");

  a_power_gate: assert property (
    @(posedge clock) disable iff (!reset_n)
    !master_power_up |=> power == '0)
    else $error("block powered while master off");

  a_regulator_off: assert property (
    @(posedge clock) disable iff (!reset_n)
    wr.valid && reg_sel(wr.addr) == 2'h2 && !wr.data[BIT_REGULATOR]
    |=> !power.regulator_enable)
    else $error("regulator left on after power down");

  a_channel_map: assert property (
    @(posedge clock) disable iff (!reset_n)
    wr.valid && reg_sel(wr.addr) == 2'h2 && master_power_up
    |=> power.channel_enable == $past(wr.data[3:0]))
    else $error("channel enable not one-to-one");

  // outputs still hold their reset zero on the first edge after release
  a_i2s_delay: assert property (
    @(posedge clock) disable iff (!reset_n)
    $past(reset_n) |->
    port_cfg.first_bit_delay == (fmt_r[FMT_LSB +: 2] == FMT_I2S))
    else $error("i2s delay flag wrong");

  a_rj_width: assert property (
    @(posedge clock) disable iff (!reset_n)
    fmt_r[FMT_LSB +: 2] == FMT_LJ |-> !port_cfg.right_justified &&
    port_cfg.data_bits == 5'h18)
    else $error("left justified decode wrong");

  a_slot_count: assert property (
    @(posedge clock) disable iff (!reset_n)
    fmt_r[SLOT_LSB +: 3] == SLOT_TDM16 |-> port_cfg.slot_count == 5'h10)
    else $error("tdm16 slot count wrong");

  a_stereo_slots: assert property (
    @(posedge clock) disable iff (!reset_n)
    port_cfg.port_slot_mode == SLOT_STEREO |-> port_cfg.slot_count == 5'h00)
    else $error("stereo mode shows slots");

  a_rate_reset: assert property (
    @(posedge clock)
    $rose(reset_n) |-> port_cfg.sample_rate_range == RATE_8_12 ##1
    port_cfg.sample_rate_range == RATE_32_48)
    else $error("rate range not at reset value");

endmodule : acpcr_top
`default_nettype wire
